// ==== logic/scc_pkg.sv ====
// synchronism check close gate: shared constants and register map
// assumes a 100 MHz relay clock and an AXI4-Lite register bus
package scc_pkg;
  // timing: figures in their own unit, cycle counts derived from the rate
  localparam int unsigned CLK_HZ   = 100_000_000;
  localparam int unsigned FAIL_MS  = 200;
  localparam int unsigned FAIL_CYC = CLK_HZ / 1000 * FAIL_MS;
  localparam int unsigned TICK_MS  = 100;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;

  // register map: global word, then one 32-byte page per stage
  localparam logic [7:0] GLOB_ADDR = 8'h00;
  localparam logic [2:0] PAGE_ST0  = 3'h1;
  localparam logic [4:0] MODE_OFF  = 5'h00;
  localparam logic [4:0] VOLT_OFF  = 5'h04;
  localparam logic [4:0] DIFF_OFF  = 5'h08;
  localparam logic [4:0] TIME_OFF  = 5'h0c;
  localparam logic [4:0] TMO_OFF   = 5'h10;
  localparam logic [4:0] STAT_OFF  = 5'h14;

  // global word fields
  localparam int GL_TWO_AUX  = 0;
  localparam int GL_AUX1_LN  = 1;
  localparam int GL_AUX2_LN  = 2;
  localparam int GL_PAIR_LSB = 4;
  // mode word fields
  localparam int MD_VEN    = 0;
  localparam int MD_DD     = 1;
  localparam int MD_DL     = 2;
  localparam int MD_LD     = 3;
  localparam int MD_SM_LSB = 4;

  typedef enum logic [1:0] {SCC_SM_OFF, SCC_SM_ASYNC, SCC_SM_SYNC}
    scc_smode_t;
  typedef enum logic [1:0] {SCC_PAIR_MAIN_A1, SCC_PAIR_MAIN_A2,
                            SCC_PAIR_A1_A2} scc_pair_t;

  // reset values
  localparam logic [31:0] GLOB_RST = 32'h0000_0000;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] VOLT_RST = 32'h0320_00c8;
  localparam logic [31:0] DIFF_RST = 32'h0064_0064;
  localparam logic [31:0] TIME_RST = 32'h0064_07d0;
  localparam logic [31:0] TMO_RST  = 32'h0000_0064;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // arithmetic constants: sqrt(3) in q8, angles in centidegrees
  localparam logic [8:0]  SQRT3_Q8 = 9'h1bb;
  localparam logic [16:0] PH_FULL  = 17'h08ca0;
  localparam logic [16:0] PH_HALF  = 17'h04650;
  localparam logic [16:0] PH_LL    = 17'h00bb8;
  localparam logic [39:0] ADV_MUL  = 40'h00_0000_0024;
  localparam logic [39:0] ADV_DIV  = 40'h00_0000_03e8;
endpackage

// ==== logic/scc_stage.sv ====
// one synchronism stage sequencer: request, timeout, fail pulse, close
// assumes sync_ok and tick come from flops in the same clock domain
`timescale 1ns/1ps
module scc_stage #(
  parameter int unsigned FAIL_CYC = scc_pkg::FAIL_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        tick,
  input  wire logic        close_cmd,
  input  wire logic        sync_ok,
  input  wire logic [15:0] timeout_ticks,
  output logic             request,
  output logic             fail,
  output logic             breaker_close
);
  typedef enum logic {SCC_IDLE, SCC_WAIT} scc_seq_t;
  typedef struct packed {
    scc_seq_t    seq;
    logic [15:0] tmo;
    logic [31:0] fcnt;
    logic        fail;
    logic        close;
  } scc_stage_state_t;

  scc_stage_state_t st_r;
  scc_stage_state_t st_nxt;
  logic             tmo_hit;

  // a zero timeout expires on the first tick rather than never
  assign tmo_hit = tick &&
    (({1'b0, st_r.tmo} + 17'h00001) >= {1'b0, timeout_ticks});

  // sequencer; fail countdown first so a fresh timeout reloads it
  always_comb begin
    st_nxt = st_r;
    st_nxt.close = 1'b0;
    if (st_r.fail) begin
      if (st_r.fcnt == 32'h0) st_nxt.fail = 1'b0;
      else st_nxt.fcnt = st_r.fcnt - 32'h1;
    end
    unique case (st_r.seq)
      SCC_IDLE: begin
        if (close_cmd) begin
          st_nxt.seq = SCC_WAIT;
          st_nxt.tmo = 16'h0;
        end
      end
      SCC_WAIT: begin
        // further close commands are dropped while waiting
        if (sync_ok) begin
          st_nxt.close = 1'b1;
          st_nxt.seq   = SCC_IDLE;
          st_nxt.tmo   = 16'h0;
        end else if (tmo_hit) begin
          st_nxt.seq  = SCC_IDLE;
          st_nxt.tmo  = 16'h0;
          st_nxt.fail = 1'b1;
          st_nxt.fcnt = 32'(FAIL_CYC - 1);
        end else if (tick) begin
          st_nxt.tmo = st_r.tmo + 16'h1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) st_r <= '0;
    else st_r <= st_nxt;
  end

  assign request       = (st_r.seq == SCC_WAIT);
  assign fail          = st_r.fail;
  assign breaker_close = st_r.close;

  start_req_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !request && close_cmd |=> request)
    else $error("close command did not open a request");
  busy_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    request && close_cmd && !sync_ok && !tick |=> request && $stable(st_r.tmo))
    else $error("close command disturbed a pending request");
  ok_close_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    request && sync_ok |=> breaker_close && !request ##1 !breaker_close)
    else $error("synchronism did not give a single close");
  tmo_fail_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    request && !sync_ok && tmo_hit |=> fail && !request && !breaker_close)
    else $error("timeout did not end request with fail");
  fail_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (fail && st_r.fcnt != 32'h0 |=> fail) and
    (fail && st_r.fcnt == 32'h0 && !tmo_hit |=> !fail))
    else $error("fail pulse length wrong");
endmodule

// ==== logic/scc_top.sv ====
// synchronism check close gate: register file, criteria, two stages
// assumes measurements arrive already scaled, one set per meas_valid
//
// Contract
// - a voltage below the dead threshold counts as dead
// - a voltage above the live threshold counts as live
// - voltage and frequency/phase criteria enable separately per stage
// - voltage mode names reference then comparison; any set of DD, DL, LD
// - frequency/phase criterion needs both live and all differences in limits
// - zero-phase mode closes early by breaker time times slip
// - within-limit mode closes early so closure meets the phase limit
// - synchronism mode off ignores frequency and phase entirely
// - a close command starts a stage request
// - request holds from start until synchronism or timeout
// - timeout without synchronism gives one fixed 200 ms fail pulse
// - synchronism in time gives an internal breaker close only
// - ok follows the synchronism conditions, request or not
// - bypass declares synchronism at all times
// - request, ok and fail of each stage are outputs for routing
// - one stage normally, two stages with two auxiliary inputs
// - stage one main versus first aux; stage two selectable pair
// - stage two converts phase-neutral aux inputs to line-line
`timescale 1ns/1ps
module scc_top #(
  parameter int unsigned TICK_CYC = scc_pkg::TICK_CYC,
  parameter int unsigned FAIL_CYC = scc_pkg::FAIL_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  close_cmd,
  input  wire logic [1:0]  bypass,
  input  wire logic        meas_valid,
  input  wire logic [15:0] main_line_voltage_mag,
  input  wire logic [15:0] main_line_voltage_freq,
  input  wire logic [15:0] main_line_voltage_phase,
  input  wire logic [15:0] first_aux_line_voltage_mag,
  input  wire logic [15:0] first_aux_line_voltage_freq,
  input  wire logic [15:0] first_aux_line_voltage_phase,
  input  wire logic [15:0] second_aux_line_voltage_mag,
  input  wire logic [15:0] second_aux_line_voltage_freq,
  input  wire logic [15:0] second_aux_line_voltage_phase,
  output logic [1:0]       sync_request,
  output logic [1:0]       sync_ok,
  output logic [1:0]       sync_fail,
  output logic [1:0]       breaker_close
);
  typedef struct packed {
    logic [7:0]       awaddr;
    logic             aw_got;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             w_got;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [31:0]      glob;
    logic [1:0][31:0] mode;
    logic [1:0][31:0] volt;
    logic [1:0][31:0] diff;
    logic [1:0][31:0] timing;
    logic [1:0][31:0] tmo;
    logic [1:0]       vok;
    logic [1:0]       fpok;
    logic [1:0]       ok;
    logic [31:0]      tick_cnt;
    logic             tick;
  } scc_top_state_t;

  scc_top_state_t   st_r;
  scc_top_state_t   st_nxt;
  logic [1:0][15:0] rm, cm, rf, cf, rp, cp;
  logic [1:0]       vok_c, fpok_c, en;
  logic [15:0]      a1m, a1p, a2m, a2p;
  logic [1:0]       wdec, rdec;
  scc_pkg::scc_pair_t pair;

  // sqrt(3) scaling, saturated so a large input cannot wrap to small
  function automatic logic [15:0] scc_ll_mag(input logic [15:0] m);
    logic [24:0] p;
    p = 25'(m) * 25'(scc_pkg::SQRT3_Q8);
    return p[24] ? 16'hffff : p[23:8];
  endfunction

  // line-line leads its phase-neutral voltage by 30 degrees
  function automatic logic [15:0] scc_ll_ph(input logic [15:0] a);
    logic [16:0] s;
    logic [16:0] t;
    s = {1'b0, a} + scc_pkg::PH_LL;
    t = (s >= scc_pkg::PH_FULL) ? s - scc_pkg::PH_FULL : s;
    return t[15:0];
  endfunction

  function automatic logic [31:0] scc_wm(input logic [31:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0]  b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction

  // address to {page hit, stage index}
  function automatic logic [1:0] scc_dec(input logic [7:0] a);
    logic [2:0] d;
    d = a[7:5] - scc_pkg::PAGE_ST0;
    return {d < 3'h2, d[0]};
  endfunction

  // stage two sees aux inputs as line-line quantities
  assign a1m = st_r.glob[scc_pkg::GL_AUX1_LN] ?
               scc_ll_mag(first_aux_line_voltage_mag) :
               first_aux_line_voltage_mag;
  assign a1p = st_r.glob[scc_pkg::GL_AUX1_LN] ?
               scc_ll_ph(first_aux_line_voltage_phase) :
               first_aux_line_voltage_phase;
  assign a2m = st_r.glob[scc_pkg::GL_AUX2_LN] ?
               scc_ll_mag(second_aux_line_voltage_mag) :
               second_aux_line_voltage_mag;
  assign a2p = st_r.glob[scc_pkg::GL_AUX2_LN] ?
               scc_ll_ph(second_aux_line_voltage_phase) :
               second_aux_line_voltage_phase;

  assign pair  = scc_pkg::scc_pair_t'(st_r.glob[scc_pkg::GL_PAIR_LSB +: 2]);
  // second stage exists only with two aux inputs
  assign en    = {st_r.glob[scc_pkg::GL_TWO_AUX], 1'b1};

  // both stages in one process so each vector keeps a single driver;
  // stage one fixed, stage two code 3 falls back to main/first aux
  always_comb begin
    rm[0] = main_line_voltage_mag;
    rf[0] = main_line_voltage_freq;
    rp[0] = main_line_voltage_phase;
    cm[0] = first_aux_line_voltage_mag;
    cf[0] = first_aux_line_voltage_freq;
    cp[0] = first_aux_line_voltage_phase;
    rm[1] = main_line_voltage_mag;
    rf[1] = main_line_voltage_freq;
    rp[1] = main_line_voltage_phase;
    cm[1] = a1m;
    cf[1] = first_aux_line_voltage_freq;
    cp[1] = a1p;
    unique case (pair)
      scc_pkg::SCC_PAIR_MAIN_A2: begin
        cm[1] = a2m;
        cf[1] = second_aux_line_voltage_freq;
        cp[1] = a2p;
      end
      scc_pkg::SCC_PAIR_A1_A2: begin
        rm[1] = a1m;
        rf[1] = first_aux_line_voltage_freq;
        rp[1] = a1p;
        cm[1] = a2m;
        cf[1] = second_aux_line_voltage_freq;
        cp[1] = a2p;
      end
      default: ;
    endcase
  end

  // per-stage criteria; angles in centidegrees, slip in mHz, time in ms
  genvar g;
  for (g = 0; g < 2; g++) begin : g_st
    logic signed [16:0] dfs, dpr, dps;
    logic [16:0] adf, adp, du;
    logic [39:0] adv;
    logic [31:0] md;
    logic [15:0] plim;
    logic rd, rl, cd, cl, appr, ph_ok, dif_ok;
    scc_pkg::scc_smode_t sm;

    assign md   = st_r.mode[g];
    assign plim = st_r.timing[g][15:0];
    assign sm   = scc_pkg::scc_smode_t'(md[scc_pkg::MD_SM_LSB +: 2]);
    assign rd   = rm[g] < st_r.volt[g][15:0];
    assign cd   = cm[g] < st_r.volt[g][15:0];
    assign rl   = rm[g] > st_r.volt[g][31:16];
    assign cl   = cm[g] > st_r.volt[g][31:16];
    assign du   = (rm[g] > cm[g]) ? {1'b0, rm[g] - cm[g]} :
                                    {1'b0, cm[g] - rm[g]};
    assign dfs  = $signed({1'b0, cf[g]}) - $signed({1'b0, rf[g]});
    assign adf  = dfs[16] ? 17'(-dfs) : 17'(dfs);
    // phase difference folded into -180..+180 degrees
    assign dpr  = $signed({1'b0, cp[g]}) - $signed({1'b0, rp[g]});
    assign dps  = (dpr > $signed(scc_pkg::PH_HALF)) ?
                    dpr - $signed(scc_pkg::PH_FULL) :
                  (dpr < -$signed(scc_pkg::PH_HALF)) ?
                    dpr + $signed(scc_pkg::PH_FULL) : dpr;
    assign adp  = dps[16] ? 17'(-dps) : 17'(dps);
    // angle slipped during the breaker closing time
    assign adv  = (40'(adf) * 40'(st_r.timing[g][31:16]) *
                   scc_pkg::ADV_MUL) / scc_pkg::ADV_DIV;
    // slip drives the angle toward zero
    assign appr = (dps == 17'sh0) || (dfs != 17'sh0 && dps[16] != dfs[16]);
    // sync aims at zero, async at the moment the limit is entered
    assign ph_ok = (sm == scc_pkg::SCC_SM_SYNC) ?
      (appr && 40'(adp) <= adv && adp <= {1'b0, plim}) :
      (adp <= {1'b0, plim} ||
       (appr && 40'(adp) <= adv + 40'(plim)));
    assign dif_ok = rl && cl && du <= {1'b0, st_r.diff[g][15:0]} &&
                    adf <= {1'b0, st_r.diff[g][31:16]};
    assign fpok_c[g] = (sm == scc_pkg::SCC_SM_ASYNC ||
                        sm == scc_pkg::SCC_SM_SYNC) &&
                       dif_ok && ph_ok;
    assign vok_c[g] = md[scc_pkg::MD_VEN] &&
                      ((md[scc_pkg::MD_DD] && rd && cd) ||
                       (md[scc_pkg::MD_DL] && rd && cl) ||
                       (md[scc_pkg::MD_LD] && rl && cd));

    // commands only ever reach the stage, never the breaker
    scc_stage #(.FAIL_CYC(FAIL_CYC)) u_stage (
      .ref_clk       (ref_clk),
      .rst_n         (rst_n),
      .tick          (st_r.tick),
      .close_cmd     (close_cmd[g] && en[g]),
      .sync_ok       (st_r.ok[g]),
      .timeout_ticks (st_r.tmo[g][15:0]),
      .request       (sync_request[g]),
      .fail          (sync_fail[g]),
      .breaker_close (breaker_close[g])
    );

    dead_eval_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      meas_valid && md[scc_pkg::MD_VEN] && md[scc_pkg::MD_DD] &&
      rm[g] < st_r.volt[g][15:0] && cm[g] < st_r.volt[g][15:0]
      |=> st_r.vok[g])
      else $error("both sides dead not accepted");
    smode_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      meas_valid && sm == scc_pkg::SCC_SM_OFF |=> !st_r.fpok[g])
      else $error("phase criterion used while off");
    need_live_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      meas_valid && !(rm[g] > st_r.volt[g][31:16] &&
                      cm[g] > st_r.volt[g][31:16]) |=> !st_r.fpok[g])
      else $error("phase criterion passed without live sides");
    bypass_ok_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      en[g] && bypass[g] |=> sync_ok[g] ##1 (sync_ok[g] || !$past(bypass[g])))
      else $error("bypass did not declare synchronism");
  end

  assign wdec = scc_dec(st_r.awaddr);
  assign rdec = scc_dec(s_axi_araddr);

  // whole-block next state: tick, criteria, bus slave
  always_comb begin
    st_nxt = st_r;
    // 100 ms tick for request timeouts
    if (st_r.tick_cnt >= 32'(TICK_CYC - 1)) begin
      st_nxt.tick_cnt = 32'h0;
      st_nxt.tick     = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 32'h1;
      st_nxt.tick     = 1'b0;
    end
    // criteria sampled once per measurement set
    if (meas_valid) begin
      st_nxt.vok  = vok_c;
      st_nxt.fpok = fpok_c;
    end
    // either enabled criterion grants; bypass overrides
    // ok is independent of any pending request
    st_nxt.ok = en & (bypass | st_r.vok | st_r.fpok);
    // write channel: address and data accepted in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.awaddr = s_axi_awaddr;
      st_nxt.aw_got = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
      st_nxt.w_got = 1'b1;
    end
    if (st_r.bvalid && s_axi_bready) st_nxt.bvalid = 1'b0;
    if (st_r.aw_got && st_r.w_got) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = scc_pkg::RESP_OKAY;
      if (st_r.awaddr == scc_pkg::GLOB_ADDR) begin
        st_nxt.glob = scc_wm(st_r.glob, st_r.wdata, st_r.wstrb);
      end else if (wdec[1]) begin
        unique case (st_r.awaddr[4:0])
          scc_pkg::MODE_OFF: st_nxt.mode[wdec[0]] =
            scc_wm(st_r.mode[wdec[0]], st_r.wdata, st_r.wstrb);
          scc_pkg::VOLT_OFF: st_nxt.volt[wdec[0]] =
            scc_wm(st_r.volt[wdec[0]], st_r.wdata, st_r.wstrb);
          scc_pkg::DIFF_OFF: st_nxt.diff[wdec[0]] =
            scc_wm(st_r.diff[wdec[0]], st_r.wdata, st_r.wstrb);
          scc_pkg::TIME_OFF: st_nxt.timing[wdec[0]] =
            scc_wm(st_r.timing[wdec[0]], st_r.wdata, st_r.wstrb);
          scc_pkg::TMO_OFF: st_nxt.tmo[wdec[0]] =
            scc_wm(st_r.tmo[wdec[0]], st_r.wdata, st_r.wstrb);
          scc_pkg::STAT_OFF: ;  // status is read-only; write dropped
          default: st_nxt.bresp = scc_pkg::RESP_SLVERR;
        endcase
      end else begin
        st_nxt.bresp = scc_pkg::RESP_SLVERR;
      end
    end
    // read channel: one read outstanding, answered next cycle
    if (st_r.rvalid && s_axi_rready) st_nxt.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = scc_pkg::RESP_OKAY;
      st_nxt.rdata  = 32'h0;
      if (s_axi_araddr == scc_pkg::GLOB_ADDR) begin
        st_nxt.rdata = st_r.glob;
      end else if (rdec[1]) begin
        unique case (s_axi_araddr[4:0])
          scc_pkg::MODE_OFF: st_nxt.rdata = st_r.mode[rdec[0]];
          scc_pkg::VOLT_OFF: st_nxt.rdata = st_r.volt[rdec[0]];
          scc_pkg::DIFF_OFF: st_nxt.rdata = st_r.diff[rdec[0]];
          scc_pkg::TIME_OFF: st_nxt.rdata = st_r.timing[rdec[0]];
          scc_pkg::TMO_OFF:  st_nxt.rdata = st_r.tmo[rdec[0]];
          scc_pkg::STAT_OFF: st_nxt.rdata = {27'h0,
            st_r.fpok[rdec[0]], st_r.vok[rdec[0]], sync_fail[rdec[0]],
            st_r.ok[rdec[0]], sync_request[rdec[0]]};
          default: st_nxt.rresp = scc_pkg::RESP_SLVERR;
        endcase
      end else begin
        st_nxt.rresp = scc_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r        <= '0;
      st_r.glob   <= scc_pkg::GLOB_RST;
      st_r.mode   <= {2{scc_pkg::MODE_RST}};
      st_r.volt   <= {2{scc_pkg::VOLT_RST}};
      st_r.diff   <= {2{scc_pkg::DIFF_RST}};
      st_r.timing <= {2{scc_pkg::TIME_RST}};
      st_r.tmo    <= {2{scc_pkg::TMO_RST}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ready terms hold off a new transfer until the response is taken
  assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;
  assign sync_ok       = st_r.ok;

  bresp_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
endmodule

// ==== test/scc_obj_model.sv ====
// object control stand-in: issues close commands, counts breaker closes
// assumes the gate samples close_cmd on the rising edge of ref_clk
`timescale 1ns/1ps
module scc_obj_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] go,
  input  wire logic [1:0] breaker_close,
  output logic      [1:0] close_cmd,
  output int              closes
);
  // commands go to the gate, never straight to the breaker
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      close_cmd <= 2'h0;
      closes    <= 0;
    end else begin
      close_cmd <= go;
      closes    <= closes + int'(breaker_close[0]) + int'(breaker_close[1]);
    end
  end
endmodule

// ==== test/testbench.sv ====
// bench for the synchronism check close gate, stage one in depth
// assumes short tick and fail counts so timeouts end quickly
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0, rst_n = 1'b0, meas_valid = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, close_cmd, go = 2'h0;
  logic [1:0] bypass = 2'h0, sync_request, sync_ok, sync_fail;
  logic [1:0] breaker_close;
  logic [15:0] main_line_voltage_mag = 16'h0;
  logic [15:0] first_aux_line_voltage_mag = 16'h0;
  logic [15:0] main_line_voltage_phase = 16'h0;
  logic [15:0] first_aux_line_voltage_phase = 16'h0;
  logic [15:0] main_line_voltage_freq = 16'hc350;
  logic [15:0] first_aux_line_voltage_freq = 16'hc350;
  int closes, n, bad_count = 0, checks = 0;

  // short counts keep the timeout and fail pulse within a few cycles
  scc_top #(.TICK_CYC(10), .FAIL_CYC(16)) scc_top_inst (
    .ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .close_cmd, .bypass, .meas_valid,
    .main_line_voltage_mag, .main_line_voltage_freq,
    .main_line_voltage_phase, .first_aux_line_voltage_mag,
    .first_aux_line_voltage_freq, .first_aux_line_voltage_phase,
    .second_aux_line_voltage_mag(16'h0000),
    .second_aux_line_voltage_freq(16'h0000),
    .second_aux_line_voltage_phase(16'h0000),
    .sync_request, .sync_ok, .sync_fail, .breaker_close);
  scc_obj_model scc_obj_model_inst (
    .ref_clk, .rst_n, .go, .breaker_close, .close_cmd, .closes);

  always #5 ref_clk = ~ref_clk;

  task automatic close_out();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk(32'(s_axi_bresp), 32'(scc_pkg::RESP_OKAY));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  // one measurement set, then enough edges for ok to settle
  task automatic meas(input logic [15:0] m0, m1, p0, p1);
    main_line_voltage_mag <= m0;
    first_aux_line_voltage_mag <= m1;
    main_line_voltage_phase <= p0;
    first_aux_line_voltage_phase <= p1;
    meas_valid <= 1'b1;
    @(posedge ref_clk);
    meas_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic pulse_go(input logic [1:0] g);
    go <= g;
    @(posedge ref_clk);
    go <= 2'h0;
  endtask

  task automatic t_regs();
    rd(8'h24, rd_v);
    chk(rd_v, scc_pkg::VOLT_RST);
    rd(8'h1c, rd_v);
    chk({rd_v[29:0], rsp}, 32'(scc_pkg::RESP_SLVERR));
    wr(8'h30, 32'h2);
    rd(8'h30, rd_v);
    chk(rd_v, 32'h2);
  endtask
  // both dead closes; stage two is absent in single aux mode
  task automatic t_dead();
    wr(8'h20, 32'h3);
    meas(16'h0, 16'h0, 16'h0, 16'h0);
    chk(32'(sync_ok[0]), 32'h1);
    pulse_go(2'b11);
    repeat (8) @(posedge ref_clk);
    chk(closes, 1);
    chk(32'(sync_request), 32'h0);
    meas(16'h0, 16'h0400, 16'h0, 16'h0);
    chk(32'(sync_ok[0]), 32'h0);
    wr(8'h20, 32'h5);
    meas(16'h0, 16'h0400, 16'h0, 16'h0);
    chk(32'(sync_ok[0]), 32'h1);
  endtask
  // live sides under dead-only mode time out into a fail pulse
  task automatic t_fail();
    wr(8'h20, 32'h3);
    meas(16'h0400, 16'h0400, 16'h0, 16'h0);
    chk(32'(sync_ok[0]), 32'h0);
    pulse_go(2'b01);
    repeat (2) @(posedge ref_clk);
    chk(32'(sync_request[0]), 32'h1);
    pulse_go(2'b01);
    for (n = 0; sync_request[0] && n < 40; n++) @(posedge ref_clk);
    chk(32'(n >= 5 && n <= 20), 32'h1);
    for (n = 0; !sync_fail[0] && n < 4; n++) @(posedge ref_clk);
    for (n = 0; sync_fail[0] && n < 40; n++) @(posedge ref_clk);
    chk(n, 16);
    chk(closes, 1);
  endtask
  task automatic t_fp();
    bypass <= 2'b01;
    repeat (3) @(posedge ref_clk);
    chk(32'(sync_ok[0]), 32'h1);
    bypass <= 2'b00;
    wr(8'h20, 32'h10);
    meas(16'h0400, 16'h0400, 16'h1000, 16'h1000);
    chk(32'(sync_ok[0]), 32'h1);
    meas(16'h0400, 16'h0400, 16'h1000, 16'h3328);
    chk(32'(sync_ok[0]), 32'h0);
    wr(8'h20, 32'h0);
    meas(16'h0400, 16'h0400, 16'h1000, 16'h1000);
    chk(32'(sync_ok[0]), 32'h0);
  endtask
  // slip 100 mHz, close time 100 ms: advance is 360 centidegrees
  task automatic t_slip();
    first_aux_line_voltage_freq <= 16'hc3b4;
    wr(8'h20, 32'h20);
    meas(16'h0400, 16'h0400, 16'h1000, 16'h0ed4);
    chk(32'(sync_ok[0]), 32'h1);
    meas(16'h0400, 16'h0400, 16'h1000, 16'h112c);
    chk(32'(sync_ok[0]), 32'h0);
    wr(8'h20, 32'h10);
    meas(16'h0400, 16'h0400, 16'h1000, 16'h0768);
    chk(32'(sync_ok[0]), 32'h1);
  endtask
  // stage two, phase-neutral first aux: 592 scales to 1024, angle +30 deg
  task automatic t_aux();
    wr(8'h00, 32'h3);
    wr(8'h40, 32'h10);
    meas(16'h0400, 16'h0250, 16'h1000, 16'h0448);
    chk(32'(sync_ok[1]), 32'h1);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_dead();
    t_fail();
    t_fp();
    t_slip();
    t_aux();
    close_out();
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    close_out();
  end
endmodule
